// ---- hw/src_ratio_path.sv ----
// Ratio path of a fractional-N synthesizer: registers, modifier, divider, modulator.
// Assumes byte writes and reads synchronous to core_clk and a synchronous reference input.
//
// Operation
// - User ratio is unsigned 12.20 fixed point.
// - Ratio reaches about 4096, step 0.954 ppm.
// - Modifier code selects x1..x8 or /2../16.
// - Modifier always applied; resets to unity.
// - Stored user ratio never altered by modifier.
// - Effective ratio equals user ratio times modifier.
// - Divide value compensates the reference divider.
// - Reference divided by 2-bit select factor.
// - User ratio sits at bytes 06h to 09h.
// - Delta-sigma carry density gives the fraction.
// - Ratio-affecting writes drop lock, then relock.
`timescale 1ns/100ps
`include "src_ratio_cfg.svh"

module src_ratio_path #(
  parameter int unsigned LOCK_CYCLES =
    (`SRC_LOCK_TIME_MS * 1000000) / `SRC_CLK_PERIOD_NS
) (
  // Clock and reset.
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  // Control port write and read.
  input  wire src_pkg::src_wr_t       wr_req,
  input  wire logic [7:0]             rd_addr,
  output logic [7:0]                  rd_data,
  // Timing reference input.
  input  wire logic                   timing_reference_clock,
  // Synthesizer controls and status.
  output logic                        internal_timing_clock,
  output logic [`SRC_EFF_W-1:0]       effective_ratio_value,
  output logic [`SRC_LDIV_W-1:0]      loop_divide_value,
  output logic                        pll_locked
);

  localparam logic [`SRC_CNT_W-1:0] LOCK_LAST = `SRC_CNT_W'(LOCK_CYCLES - 1);

  src_pkg::src_state_t q;
  src_pkg::src_state_t d;
  logic [1:0]              div_last;
  logic [1:0]              div_shift;
  logic [1:0]              mod_up;
  logic [2:0]              mod_dn;
  logic [`SRC_EFF_W-1:0]   base;
  logic [`SRC_EFF_W-1:0]   corr;
  logic [`SRC_FRAC_W:0]    sum;

  // =============================================================
  // Next-state logic
  // Computes every field of the next state from the current state and inputs.
  always_comb begin
    d = q;
    // Divider select maps to the last count and to the compensation shift.
    case (q.div_sel)
      `SRC_DIV_CODE_BY1: begin
        div_last  = 2'h0;
        div_shift = 2'h0;
      end
      `SRC_DIV_CODE_BY2: begin
        div_last  = 2'h1;
        div_shift = 2'h1;
      end
      default: begin
        div_last  = 2'h3;
        div_shift = 2'h2;
      end
    endcase
    // Reference rising edges are counted down to one internal tick.
    d.ref_prev = timing_reference_clock;
    d.tick     = 1'b0;
    if (timing_reference_clock && !q.ref_prev) begin
      if (q.ref_cnt == div_last) begin
        d.ref_cnt = 2'h0;
        d.tick    = 1'b1;
      end else begin
        d.ref_cnt = q.ref_cnt + 2'h1;
      end
    end
    // Modifier: low codes shift up, high codes shift down by one more.
    mod_up = q.mod_sel[2] ? 2'h0 : q.mod_sel[1:0];
    mod_dn = q.mod_sel[2] ? ({1'b0, q.mod_sel[1:0]} + 3'h1) : 3'h0;
    // The 12.20 ratio gains guard bits so a sixteenth loses nothing.
    base   = {5'h00, q.ratio, {`SRC_GUARD_W{1'b0}}};
    d.eff  = (base << mod_up) >> mod_dn;
    // The divided reference needs the ratio scaled up by the divide factor.
    corr   = q.eff << div_shift;
    sum    = {1'b0, q.acc} + {1'b0, corr[`SRC_FRAC_W-1:0]};
    if (q.tick) begin
      d.acc      = sum[`SRC_FRAC_W-1:0];
      d.loop_div = {1'b0, corr[`SRC_EFF_W-1:`SRC_FRAC_W]} +
                   {{(`SRC_LDIV_W-1){1'b0}}, sum[`SRC_FRAC_W]};
    end
    // Register writes; the ratio bytes go most significant first.
    if (wr_req.en) begin
      case (wr_req.addr)
        `SRC_ADDR_RATIO_B3: d.ratio[31:24] = wr_req.data;
        `SRC_ADDR_RATIO_B2: d.ratio[23:16] = wr_req.data;
        `SRC_ADDR_RATIO_B1: d.ratio[15:8]  = wr_req.data;
        `SRC_ADDR_RATIO_B0: d.ratio[7:0]   = wr_req.data;
        `SRC_ADDR_MOD_SEL:  d.mod_sel      = wr_req.data[`SRC_MOD_W-1:0];
        `SRC_ADDR_DIV_SEL:  d.div_sel      = wr_req.data[`SRC_DIV_W-1:0];
        default: begin
        end
      endcase
    end
    // A changed ratio, modifier or divider restarts the lock wait.
    if ((d.ratio != q.ratio) || (d.mod_sel != q.mod_sel) ||
        (d.div_sel != q.div_sel)) begin
      d.lock_st  = src_pkg::src_relock;
      d.lock_cnt = LOCK_LAST;
      d.acc      = '0;
      d.ref_cnt  = '0;                                           // Drops any stale phase.
    end else begin
      case (q.lock_st)
        src_pkg::src_relock: begin
          if (q.lock_cnt == '0) begin
            d.lock_st = src_pkg::src_locked;
          end else begin
            d.lock_cnt = q.lock_cnt - `SRC_CNT_W'(1);
          end
        end
        src_pkg::src_locked: d.lock_st = src_pkg::src_locked;
        default:             d.lock_st = src_pkg::src_relock;
      endcase
    end
    // Read mux; unmapped addresses return zero.
    case (rd_addr)
      `SRC_ADDR_RATIO_B3: d.rd_data = q.ratio[31:24];
      `SRC_ADDR_RATIO_B2: d.rd_data = q.ratio[23:16];
      `SRC_ADDR_RATIO_B1: d.rd_data = q.ratio[15:8];
      `SRC_ADDR_RATIO_B0: d.rd_data = q.ratio[7:0];
      `SRC_ADDR_MOD_SEL:  d.rd_data = {5'h00, q.mod_sel};
      `SRC_ADDR_DIV_SEL:  d.rd_data = {6'h00, q.div_sel};
      `SRC_ADDR_STATUS:   d.rd_data = {7'h00, q.lock_st == src_pkg::src_locked};
      default:            d.rd_data = 8'h00;
    endcase
  end

  // =============================================================
  // State register
  // Holds the whole state; reset gives unity modifier and a fresh lock wait.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      q          <= '0;
      q.ratio    <= `SRC_RATIO_RESET;
      q.mod_sel  <= `SRC_MOD_SEL_RESET;
      q.div_sel  <= `SRC_DIV_SEL_RESET;
      q.lock_cnt <= LOCK_LAST;
    end else begin
      q <= d;
    end
  end

  // Outputs come straight from the state register.
  assign rd_data               = q.rd_data;
  assign internal_timing_clock = q.tick;
  assign effective_ratio_value = q.eff;
  assign loop_divide_value     = q.loop_div;
  assign pll_locked            = (q.lock_st == src_pkg::src_locked);

  // =============================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  logic [`SRC_EFF_W-1:0] corr_q;
  always_ff @(posedge core_clk) begin
    corr_q <= corr;
  end

  // Reset leaves the modifier at unity.
  a_mod_reset_unity: assert property (@(posedge core_clk) disable iff (1'b0)
    sys_rst |=> q.mod_sel == `SRC_MOD_SEL_RESET) else $error("modifier not unity after reset");
  // Unity modifier passes the guarded ratio through one cycle later.
  a_eff_unity_pass: assert property (
    q.mod_sel == 3'h0 |=> q.eff == {5'h00, $past(q.ratio), 4'h0})
    else $error("effective ratio wrong at unity");
  // Divide by sixteen keeps every guarded bit.
  a_eff_sixteenth: assert property (
    q.mod_sel == 3'h7 |=> q.eff == {9'h000, $past(q.ratio)})
    else $error("sixteenth modifier lost bits");
  // A top ratio byte write lands in the register.
  a_ratio_byte_write: assert property (
    wr_req.en && wr_req.addr == `SRC_ADDR_RATIO_B3 |=> q.ratio[31:24] == $past(wr_req.data))
    else $error("ratio top byte not written");
  // A modifier write never changes the stored ratio.
  a_ratio_kept_mod: assert property (
    wr_req.en && wr_req.addr == `SRC_ADDR_MOD_SEL |=> $stable(q.ratio))
    else $error("ratio changed by modifier write");
  // A changing divider write drops lock for at least two cycles.
  a_write_drops_lock: assert property (
    wr_req.en && wr_req.addr == `SRC_ADDR_DIV_SEL && wr_req.data[1:0] != q.div_sel
    |=> !pll_locked [*2]) else $error("lock not dropped on divider change");
  // Lock only returns once the wait count is spent.
  a_lock_after_wait: assert property (
    $rose(pll_locked) |-> $past(q.lock_cnt) == '0) else $error("early relock");
  // Divide by one ticks on the edge right after each reference rise.
  a_tick_by_one: assert property (
    q.div_sel == 2'h0 && timing_reference_clock && !q.ref_prev
    && !(wr_req.en && wr_req.addr == `SRC_ADDR_DIV_SEL) |=> internal_timing_clock)
    else $error("missing tick at divide by one");
  // Loop divide is the integer part or one above it.
  a_dsm_divide_range: assert property (
    q.tick ##1 $stable(corr_q)
    |-> loop_divide_value - {1'b0, corr_q[`SRC_EFF_W-1:`SRC_FRAC_W]} <= 18'h0_0001)
    else $error("loop divide out of range");

  c_lock_regained: cover property ($rose(pll_locked));
  c_mod_by_eight: cover property (q.mod_sel == 3'h3 && q.tick);
  c_dsm_carry: cover property (q.tick && sum[`SRC_FRAC_W]);

endmodule

// ---- hw/src_ratio_cfg.svh ----
// Constants for the synthesizer ratio path: register offsets, field widths and timing.
// Assumes inclusion by src_pkg, by the ratio path module and by the testbench.
`ifndef SRC_RATIO_CFG_SVH
`define SRC_RATIO_CFG_SVH

// =============================================================
// Register byte offsets on the control port
`define SRC_ADDR_RATIO_B3   8'h06
`define SRC_ADDR_RATIO_B2   8'h07
`define SRC_ADDR_RATIO_B1   8'h08
`define SRC_ADDR_RATIO_B0   8'h09
`define SRC_ADDR_MOD_SEL    8'h03
`define SRC_ADDR_DIV_SEL    8'h04
`define SRC_ADDR_STATUS     8'h05

// =============================================================
// Field widths and fixed-point layout
`define SRC_RATIO_W         32
`define SRC_RATIO_INT_W     12
`define SRC_RATIO_FRAC_W    20
`define SRC_GUARD_W         4
`define SRC_FRAC_W          24
`define SRC_EFF_W           41
`define SRC_LDIV_W          18
`define SRC_MOD_W           3
`define SRC_DIV_W           2
`define SRC_CNT_W           18

// =============================================================
// Reset values and divider codes
`define SRC_MOD_SEL_RESET   3'h0
`define SRC_DIV_SEL_RESET   2'h0
`define SRC_RATIO_RESET     32'h0000_0000
`define SRC_DIV_CODE_BY1    2'h0
`define SRC_DIV_CODE_BY2    2'h1

// =============================================================
// Lock timing: longest lock time in ms and clock period in ns
`define SRC_LOCK_TIME_MS    2
`define SRC_CLK_PERIOD_NS   8

`endif

// ---- hw/src_pkg.sv ----
// Types shared by the synthesizer ratio path.
// Assumes src_ratio_cfg.svh is on the include path.
`include "src_ratio_cfg.svh"

package src_pkg;

  // Byte write request from the control port.
  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } src_wr_t;

  // Lock sequencing states.
  typedef enum logic {
    src_relock,
    src_locked
  } src_lock_t;

  // Whole state of the ratio path.
  typedef struct packed {
    logic [`SRC_RATIO_W-1:0] ratio;
    logic [`SRC_MOD_W-1:0]   mod_sel;
    logic [`SRC_DIV_W-1:0]   div_sel;
    logic                    ref_prev;
    logic [1:0]              ref_cnt;
    logic                    tick;
    logic [`SRC_FRAC_W-1:0]  acc;
    logic [`SRC_EFF_W-1:0]   eff;
    logic [`SRC_LDIV_W-1:0]  loop_div;
    src_lock_t               lock_st;
    logic [`SRC_CNT_W-1:0]   lock_cnt;
    logic [7:0]              rd_data;
  } src_state_t;

endpackage

// ---- test/test_synth_ratio_computation.sv ----
// Testbench for the synthesizer ratio path: registers, modifier, lock wait and modulator.
// Assumes hw/ is on the include path and the ratio path module is compiled first.
`timescale 1ns/100ps
`include "src_ratio_cfg.svh"

module test_synth_ratio_computation;
  localparam int LC = 8;
  // =============================================================
  // Signals
  logic                     core_clk, sys_rst, timing_reference_clock;
  src_pkg::src_wr_t         wr_req;
  logic [7:0]               rd_addr, rd_data, b;
  logic                     tick, locked, tick_seen;
  logic [`SRC_EFF_W-1:0]    eff;
  logic [`SRC_LDIV_W-1:0]   loop_div;
  logic [31:0]              r;
  int                       num_errors, checks, tick_cnt, div_sum, n;

  src_ratio_path #(.LOCK_CYCLES(LC)) src_ratio_path_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .wr_req(wr_req), .rd_addr(rd_addr),
    .rd_data(rd_data), .timing_reference_clock(timing_reference_clock),
    .internal_timing_clock(tick), .effective_ratio_value(eff),
    .loop_divide_value(loop_div), .pll_locked(locked));

  // Free-running 8 ns clock.
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Counts divided ticks and sums the divide value that follows each tick.
  always @(negedge core_clk) begin
    if (tick_seen) div_sum += int'(loop_div);
    if (tick === 1'b1) tick_cnt++;
    tick_seen = (tick === 1'b1);
  end

  // =============================================================
  // Tasks
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step(1);
    wr_req = '{1'b1, a, d};
    step(1);
    wr_req.en = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    step(1);
    rd_addr = a;
    step(2);
    d = rd_data;
  endtask

  task automatic wr_ratio(input logic [31:0] v);
    for (int i = 0; i < 4; i++) wr(8'h06 + 8'(i), v[31-8*i -: 8]);
  endtask

  task automatic rd_ratio(output logic [31:0] v);
    for (int i = 0; i < 4; i++) rd(8'h06 + 8'(i), v[31-8*i -: 8]);
  endtask

  // Bounded wait for lock; running out ends the run as a failure.
  task automatic wait_lock;
    for (int i = 0; i < 100 && locked !== 1'b1; i++) step(1);
    if (locked !== 1'b1) begin
      num_errors++;
      give_verdict();
    end
  endtask

  // Expected effective ratio: 12.20 widened to 17.24, then shifted by the modifier.
  function automatic logic [40:0] eff_exp(input logic [31:0] v, input logic [2:0] m);
    logic [40:0] g;
    g = {5'h00, v, 4'h0};
    return m[2] ? g >> ({1'b0, m[1:0]} + 3'h1) : g << m[1:0];
  endfunction

  // =============================================================
  // Main sequence
  initial begin
    wr_req = '0;
    rd_addr = 8'h00;
    timing_reference_clock = 1'b0;
    sys_rst = 1'b1;
    {num_errors, checks, tick_cnt, div_sum, tick_seen} = '0;
    step(8);
    sys_rst = 1'b0;
    check("lock_after_reset", locked, 0);
    // Reset values, including an unmapped address.
    for (int i = 0; i < 7; i++) begin
      rd(i == 6 ? 8'h0A : (i < 4 ? 8'h06 + 8'(i) : 8'h03 + 8'(i - 4)), b);
      check("reset_read", b, 0);
    end
    wait_lock();
    // Every modifier code; stored ratio must stay untouched.
    // A ratio just above one keeps even the x8 modifier inside the format.
    wr_ratio(32'h0010_000F);
    for (int m = 0; m < 8; m++) begin
      wr(8'h03, 8'(m));
      wait_lock();
      check("eff_ratio", eff, eff_exp(32'h0010_000F, 3'(m)));
      rd_ratio(r);
      check("user_ratio", r, 32'h0010_000F);
    end
    wr(8'h03, 8'h00);
    wait_lock();
    // Lock drops at the write edge and returns exactly LC edges after it.
    wr(8'h08, 8'h55);
    step(1);
    check("lock_drop", locked, 0);
    step(LC - 2);
    check("lock_wait", locked, 0);
    step(1);
    check("lock_back", locked, 1);
    // Identical, unmapped and masked writes must not disturb lock.
    wr(8'h08, 8'h55);
    wr(8'h0A, 8'hFF);
    wr(8'h03, 8'hF8);
    step(1);
    check("lock_hold", locked, 1);
    rd(8'h03, b);
    check("mod_masked", b, 0);
    rd(8'h05, b);
    check("status_lock", b[0], 1);
    // Ratio 1.5: every divider setting must give 24 loop counts per 16 rises.
    wr_ratio(32'h0018_0000);
    for (int d = 0; d < 4; d++) begin
      wr(8'h04, 8'(d));
      wait_lock();
      n = (d == 0) ? 1 : (d == 1) ? 2 : 4;
      tick_cnt = 0;
      div_sum = 0;
      repeat (16) begin
        timing_reference_clock = 1'b1;
        step(1);
        timing_reference_clock = 1'b0;
        step(1);
      end
      step(4);
      check("tick_count", tick_cnt, 16 / n);
      check("divide_sum", div_sum, 24);
    end
    give_verdict();
  end
endmodule
